// ---- shared/ppc_consts.vh ----
// constants for the port pin configuration block
// assumes an 8-bit port with indexed sub-registers behind an address/control pair
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH
`define PPC_IDX_OUT_CTRL   8'h03
`define PPC_IDX_HIGH_DRIVE 8'h04
`define PPC_IDX_WAKE_SRC   8'h05
`define PPC_IDX_ALT_FUNC   8'h02
`define PPC_IDX_DATA_DIR   8'h01
`define PPC_RST_DATA_DIR   8'hFF
`define PPC_RST_SUBREG     8'h00
`define PPC_RST_INDEX      8'h00
`endif

// ---- src/ppc_pin_drive.v ----
// per-pin output driver: data, direction, alternate function, open drain
// assumes alternate-function values come from the peripherals already resolved
module ppc_pin_drive (
  // configuration
  input  wire alt_en_i,
  input  wire dir_in_i,
  input  wire open_drain_i,
  // data
  input  wire pin_output_value_i,
  input  wire alt_out_i,
  input  wire alt_oe_i,
  // pin
  output reg  pad_out_o,
  output reg  pad_oe_o
);
  reg val;
  reg drv;
  always @* begin
    if (alt_en_i) begin
      val = alt_out_i;
      drv = alt_oe_i;
    end else begin
      val = pin_output_value_i;
      drv = ~dir_in_i;
    end
    pad_out_o = val;
    // open drain releases a high level
    pad_oe_o = drv & ~(open_drain_i & val);
  end
endmodule

// ---- src/ppc_wake_detect.v ----
// transition detector for stop-mode recovery on enabled pins
// assumes pin inputs are synchronous to the clock
module ppc_wake_detect (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       reset_n_i,
  // control
  input  wire       stop_mode_i,
  input  wire [7:0] enable_i,
  input  wire [7:0] pin_i,
  // result
  output reg        wake_o
);
  reg [7:0] last;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last   <= 8'h00;
      wake_o <= 1'b0;
    end else begin
      last   <= pin_i;
      wake_o <= stop_mode_i & (|((last ^ pin_i) & enable_i));
    end
  end
endmodule

// ---- src/ppc_port_a.v ----
// first-port configuration: indexed sub-registers, fixed alternate map, pin drive
// assumes a byte-wide register strobe interface from the core, synchronous pins
`include "ppc_consts.vh"
module ppc_port_a (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       reset_n_i,
  // register access
  input  wire       addr_wr_i,
  input  wire       ctrl_wr_i,
  input  wire       out_wr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] addr_rdata_o,
  output reg  [7:0] ctrl_rdata_o,
  output reg  [7:0] out_rdata_o,
  // timer a
  input  wire       timer_a_output_i,
  input  wire       timer_a_compl_i,
  input  wire       timer_a_in_mode_i,
  output reg        timer_a_input_o,
  // timer b
  input  wire       timer_b_output_i,
  input  wire       timer_b_compl_i,
  input  wire       timer_b_in_mode_i,
  output reg        timer_b_input_o,
  // uart
  input  wire       uart_driver_enable_i,
  input  wire       uart_transmit_i,
  output reg        uart_clear_to_send_o,
  output reg        uart_receive_o,
  // stop mode
  input  wire       stop_mode_i,
  output reg        stop_recover_o,
  // pins
  input  wire [7:0] pad_in_i,
  output reg  [7:0] pad_out_o,
  output reg  [7:0] pad_oe_o,
  output reg  [7:0] pad_high_drive_o
);
  reg  [7:0] port_index;
  reg  [7:0] data_dir;
  reg  [7:0] alt_func_en;
  reg  [7:0] out_ctrl;
  reg  [7:0] port_high_drive_enable;
  reg  [7:0] port_wake_source_enable;
  reg  [7:0] pin_output_value;
  reg  [7:0] alt_out;
  reg  [7:0] alt_oe;
  reg  [7:0] next_ctrl_rdata;
  wire [7:0] next_pad_out;
  wire [7:0] next_pad_oe;
  wire       wake;

  function sel;
    input [7:0] idx;
    input [7:0] want;
    begin
      sel = (idx == want);
    end
  endfunction

  // register writes; control access goes to the held index
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_index              <= `PPC_RST_INDEX;
      data_dir                <= `PPC_RST_DATA_DIR;
      alt_func_en             <= `PPC_RST_SUBREG;
      out_ctrl                <= `PPC_RST_SUBREG;
      port_high_drive_enable  <= `PPC_RST_SUBREG;
      port_wake_source_enable <= `PPC_RST_SUBREG;
      pin_output_value        <= `PPC_RST_SUBREG;
    end else begin
      if (addr_wr_i)
        port_index <= wdata_i;
      if (out_wr_i)
        pin_output_value <= wdata_i;
      if (ctrl_wr_i) begin
        if (sel(port_index, `PPC_IDX_DATA_DIR))
          data_dir <= wdata_i;
        if (sel(port_index, `PPC_IDX_ALT_FUNC))
          alt_func_en <= wdata_i;
        if (sel(port_index, `PPC_IDX_OUT_CTRL))
          out_ctrl <= wdata_i;
        if (sel(port_index, `PPC_IDX_HIGH_DRIVE))
          port_high_drive_enable <= wdata_i;
        if (sel(port_index, `PPC_IDX_WAKE_SRC))
          port_wake_source_enable <= wdata_i;
      end
    end
  end

  // read mux for control register; unmapped indices read zero
  always @* begin
    case (port_index)
      `PPC_IDX_DATA_DIR:   next_ctrl_rdata = data_dir;
      `PPC_IDX_ALT_FUNC:   next_ctrl_rdata = alt_func_en;
      `PPC_IDX_OUT_CTRL:   next_ctrl_rdata = out_ctrl;
      `PPC_IDX_HIGH_DRIVE: next_ctrl_rdata = port_high_drive_enable;
      `PPC_IDX_WAKE_SRC:   next_ctrl_rdata = port_wake_source_enable;
      default:             next_ctrl_rdata = 8'h00;
    endcase
  end

  // fixed alternate map, single function per pin, no set selection
  always @* begin
    alt_out = 8'h00;
    alt_oe  = 8'h00;
    // pin 0: timer a input or complement output
    alt_out[0] = timer_a_compl_i;
    alt_oe[0]  = ~timer_a_in_mode_i;
    alt_out[1] = timer_a_output_i;
    alt_oe[1]  = 1'b1;
    alt_out[2] = uart_driver_enable_i;
    alt_oe[2]  = 1'b1;
    alt_out[5] = uart_transmit_i;
    alt_oe[5]  = 1'b1;
    // pin 6: timer b input or complement output
    alt_out[6] = timer_b_compl_i;
    alt_oe[6]  = ~timer_b_in_mode_i;
    alt_out[7] = timer_b_output_i;
    alt_oe[7]  = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pin
      ppc_pin_drive u_drv (
        .alt_en_i           (alt_func_en[g]),
        .dir_in_i           (data_dir[g]),
        .open_drain_i       (out_ctrl[g]),
        .pin_output_value_i (pin_output_value[g]),
        .alt_out_i          (alt_out[g]),
        .alt_oe_i           (alt_oe[g]),
        .pad_out_o          (next_pad_out[g]),
        .pad_oe_o           (next_pad_oe[g])
      );
    end
  endgenerate

  ppc_wake_detect u_wake (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .stop_mode_i (stop_mode_i),
    .enable_i    (port_wake_source_enable),
    .pin_i       (pad_in_i),
    .wake_o      (wake)
  );

  // registered outputs
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_rdata_o         <= 8'h00;
      ctrl_rdata_o         <= 8'h00;
      out_rdata_o          <= 8'h00;
      pad_out_o            <= 8'h00;
      pad_oe_o             <= 8'h00;
      pad_high_drive_o     <= 8'h00;
      timer_a_input_o      <= 1'b0;
      timer_b_input_o      <= 1'b0;
      uart_clear_to_send_o <= 1'b0;
      uart_receive_o       <= 1'b0;
      stop_recover_o       <= 1'b0;
    end else begin
      addr_rdata_o         <= port_index;
      ctrl_rdata_o         <= next_ctrl_rdata;
      out_rdata_o          <= pin_output_value;
      pad_out_o            <= next_pad_out;
      pad_oe_o             <= next_pad_oe;
      pad_high_drive_o     <= port_high_drive_enable;
      timer_a_input_o      <= alt_func_en[0] & timer_a_in_mode_i & pad_in_i[0];
      timer_b_input_o      <= alt_func_en[6] & timer_b_in_mode_i & pad_in_i[6];
      uart_clear_to_send_o <= alt_func_en[3] & pad_in_i[3];
      uart_receive_o       <= ~alt_func_en[4] | pad_in_i[4];
      stop_recover_o       <= wake;
    end
  end
endmodule

// ---- verif/ppc_port_a_monitor.sv ----
// concurrent checks on the first-port configuration block
// assumes the pads reach pad_in_i through the pin model
module ppc_port_a_monitor (
  input wire       sys_clk_i,
  input wire       reset_n_i,
  input wire       addr_wr_i,
  input wire       ctrl_wr_i,
  input wire       out_wr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] addr_rdata_o,
  input wire [7:0] ctrl_rdata_o,
  input wire [7:0] out_rdata_o,
  input wire       timer_b_in_mode_i,
  input wire       timer_b_input_o,
  input wire       uart_clear_to_send_o,
  input wire       uart_receive_o,
  input wire       stop_mode_i,
  input wire       stop_recover_o,
  input wire [7:0] pad_in_i,
  input wire [7:0] pad_high_drive_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // control write with a settled index
  sequence s_sel_wr(idx);
    ctrl_wr_i && !$past(addr_wr_i) && addr_rdata_o == idx ##1 !addr_wr_i;
  endsequence
  a_high_drive_wr: assert property (s_sel_wr(8'h04) |=> pad_high_drive_o == $past(wdata_i, 2))
    else $error("high drive copy mismatch");
  a_wake_reg_wr: assert property (s_sel_wr(8'h05) |=> ctrl_rdata_o == $past(wdata_i, 2))
    else $error("wake source readback mismatch");
  // index echo lags one cycle; skip the cycle after an index write
  a_unmapped_zero: assert property (!addr_wr_i && !$past(addr_wr_i) && (addr_rdata_o == 8'h00 || addr_rdata_o > 8'h05)
    |=> ctrl_rdata_o == 8'h00)
    else $error("unmapped index not zero");
  a_index_echo: assert property (addr_wr_i |-> ##2 addr_rdata_o == $past(wdata_i, 2))
    else $error("index readback mismatch");
  a_out_echo: assert property (out_wr_i |-> ##2 out_rdata_o == $past(wdata_i, 2))
    else $error("output data readback mismatch");
  a_reset_clear: assert property ($rose(reset_n_i) |-> pad_high_drive_o == 8'h00 && ctrl_rdata_o == 8'h00)
    else $error("sub-register not clear after reset");
  a_wake_cause: assert property (stop_recover_o |-> $past(stop_mode_i, 2) && $past(pad_in_i, 2) != $past(pad_in_i, 3))
    else $error("recovery without pin edge");
  a_wake_idle: assert property (!stop_mode_i [*3] |=> !stop_recover_o)
    else $error("recovery outside stop mode");
  a_timer_in_gate: assert property (timer_b_input_o |-> $past(pad_in_i[6]) && $past(timer_b_in_mode_i))
    else $error("timer input without pin level");
  a_uart_inputs: assert property ((uart_clear_to_send_o |-> $past(pad_in_i[3])) and (!uart_receive_o |-> !$past(pad_in_i[4])))
    else $error("uart input not from pin");
endmodule
bind ppc_port_a ppc_port_a_monitor u_ppc_port_a_monitor (.sys_clk_i, .reset_n_i, .addr_wr_i, .ctrl_wr_i,
  .out_wr_i, .wdata_i, .addr_rdata_o, .ctrl_rdata_o, .out_rdata_o, .timer_b_in_mode_i, .timer_b_input_o,
  .uart_clear_to_send_o, .uart_receive_o, .stop_mode_i, .stop_recover_o, .pad_in_i, .pad_high_drive_o);

// ---- verif/ppc_pin_world.sv ----
// pin-side model: external drivers and pull-downs on the eight pads
// assumes pad enables are high while the block drives a pin
module ppc_pin_world (
  input  wire [7:0] pad_out_i,
  input  wire [7:0] pad_oe_i,
  input  wire [7:0] ext_drive_i,
  input  wire [7:0] ext_level_i,
  output wire [7:0] pad_level_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // released pins take ext_level_i where ext_drive_i is set, else fall to the pull-down level
  assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_drive_i & ext_level_i);
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the first-port configuration block
// assumes the pin model closes the loop from pads back to pad_in_i
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 0, reset_n_i = 0, addr_wr_i = 0, ctrl_wr_i = 0, out_wr_i = 0, stop_mode_i = 0;
  logic ta_out = 0, ta_cmp = 0, ta_mode = 0, tb_out = 0, tb_cmp = 0, tb_mode = 0, de = 0, tx = 0;
  logic [7:0] wdata_i = 0, ext_drive = 0, ext_level = 0;
  wire  [7:0] addr_rd, ctrl_rd, out_rd, pad_in, pad_out, pad_oe, pad_hd;
  wire        ta_in, tb_in, cts, rx, wake;
  int         miscompares = 0, tests_run = 0;
  bit         seen;
  always #2.5 sys_clk_i = ~sys_clk_i;
  ppc_port_a u_ppc_port_a (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_wr_i(addr_wr_i),
    .ctrl_wr_i(ctrl_wr_i), .out_wr_i(out_wr_i), .wdata_i(wdata_i), .addr_rdata_o(addr_rd),
    .ctrl_rdata_o(ctrl_rd), .out_rdata_o(out_rd), .timer_a_output_i(ta_out), .timer_a_compl_i(ta_cmp),
    .timer_a_in_mode_i(ta_mode), .timer_a_input_o(ta_in), .timer_b_output_i(tb_out),
    .timer_b_compl_i(tb_cmp), .timer_b_in_mode_i(tb_mode), .timer_b_input_o(tb_in),
    .uart_driver_enable_i(de), .uart_transmit_i(tx), .uart_clear_to_send_o(cts), .uart_receive_o(rx),
    .stop_mode_i(stop_mode_i), .stop_recover_o(wake), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .pad_high_drive_o(pad_hd));
  ppc_pin_world u_pin_world (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_drive_i(ext_drive),
    .ext_level_i(ext_level), .pad_level_o(pad_in));
  // one strobe: 4 index, 2 control, 1 output data
  task wr(input logic [2:0] s, input logic [7:0] v);
    @(posedge sys_clk_i);
    {addr_wr_i, ctrl_wr_i, out_wr_i} <= s;
    wdata_i <= v;
    @(posedge sys_clk_i);
    {addr_wr_i, ctrl_wr_i, out_wr_i} <= 3'h0;
  endtask
  task settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wait_wake;
    seen = 0;
    repeat (6) begin
      @(posedge sys_clk_i);
      #1;
      if (wake === 1'b1) seen = 1;
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1;
    wr(4, 8'h04); settle; chk(ctrl_rd, 8'h00);
    wr(4, 8'h05); settle; chk(ctrl_rd, 8'h00);
    wr(2, 8'hC3); settle; chk(ctrl_rd, 8'hC3);
    wr(4, 8'h04); wr(2, 8'h3C); wr(2, 8'hA5); settle; chk(ctrl_rd, 8'hA5);
    chk(pad_hd, 8'hA5);
    wr(4, 8'h07); wr(2, 8'hFF); settle; chk(ctrl_rd, 8'h00);
    wr(4, 8'h05); settle; chk(ctrl_rd, 8'hC3);
    $display("test registers done");
    wr(4, 8'h01); wr(2, 8'h00); wr(1, 8'h0F); settle;
    chk(pad_out, 8'h0F); chk(pad_oe, 8'hFF); chk(out_rd, 8'h0F);
    wr(4, 8'h03); wr(2, 8'hFF); settle; chk(pad_oe, 8'hF0);
    wr(2, 8'h00); settle; chk(pad_oe, 8'hFF);
    $display("test drive done");
    ta_out <= 1; tb_cmp <= 1; tb_mode <= 1; tx <= 1;
    ext_drive <= 8'h58; ext_level <= 8'h48;
    wr(4, 8'h02); wr(2, 8'hFF); settle;
    chk(pad_oe, 8'hA7); chk(pad_out & 8'hA7, 8'h22);
    chk(pad_hd, 8'hA5);
    chk({5'h00, tb_in, cts, rx}, 8'h06);
    ta_mode <= 1; ext_drive <= 8'h59; ext_level <= 8'h49; settle;
    chk(pad_oe, 8'hA6);
    chk({7'h00, ta_in}, 8'h01);
    $display("test alternate done");
    wr(4, 8'h05); wr(2, 8'h10); stop_mode_i <= 1; settle;
    ext_level <= 8'h58; wait_wake; chk({7'h00, seen}, 8'h01);
    ext_level <= 8'h50; wait_wake; chk({7'h00, seen}, 8'h00);
    stop_mode_i <= 0; settle;
    ext_level <= 8'h40; wait_wake; chk({7'h00, seen}, 8'h00);
    $display("test wake done");
    report_and_stop;
  end
endmodule
